// ==== verilog/bam_pkg.sv ====
//==========================================================
// Purpose: shared constants and carriers of the byte alu datapath
// Assumes: one clock, synchronous reset
// Notes:   register bus map, opcode fields, flag layout
package bam_pkg;
	localparam int DATA_W = 8;
	localparam int INSN_W = 16;
	localparam int PROD_W = 16;
	localparam int FILE_DEPTH = 256;
	localparam int FILE_AW = 8;

	// register file locations of special registers
	localparam logic [7:0] LOC_ACC    = 8'h0A;
	localparam logic [7:0] LOC_STATUS = 8'h04;
	localparam logic [7:0] LOC_PCL    = 8'h02;
	localparam logic [7:0] LOC_PCH    = 8'h03;
	localparam logic [7:0] LOC_PRODL  = 8'h18;
	localparam logic [7:0] LOC_PRODH  = 8'h19;

	// status bit positions
	localparam int FLG_C  = 0;
	localparam int FLG_DC = 1;
	localparam int FLG_Z  = 2;
	localparam int FLG_OV = 3;
	localparam int SIGN_BIT = 7;
	localparam int MAG_MSB  = 6;
	localparam int NIB_BIT  = 4;

	// bus map, byte addresses
	localparam logic [11:0] ADDR_INSN   = 12'h000;
	localparam logic [11:0] ADDR_ACC    = 12'h004;
	localparam logic [11:0] ADDR_STATUS = 12'h008;
	localparam logic [11:0] ADDR_PROD   = 12'h00C;
	localparam logic [11:0] ADDR_PC     = 12'h010;
	localparam logic [11:0] ADDR_CYCLES = 12'h014;
	localparam logic [11:0] ADDR_FILE   = 12'h400;
	localparam logic [11:0] FILE_MASK   = 12'hC00;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD    = 3'h2;
	localparam int STALL_CYCLES = 1;

	// opcode field: insn[15:12] operation, [8] dest is file, [7:0] file addr
	typedef enum logic [3:0] {
		OP_ADD  = 4'h0, OP_SUB  = 4'h1, OP_AND  = 4'h2, OP_OR   = 4'h3,
		OP_XOR  = 4'h4, OP_RLC  = 4'h5, OP_RRC  = 4'h6, OP_MUL  = 4'h7,
		OP_MOVF = 4'h8, OP_MOVW = 4'h9, OP_MOVFF = 4'hA, OP_BRA = 4'hB,
		OP_TBL  = 4'hC, OP_NOP  = 4'hF
	} bam_op_type;

	typedef struct packed {
		logic [7:0] res;
		logic       c;
		logic       dc;
		logic       z;
		logic       ov;
		logic       upd_c;
		logic       upd_z;
	} bam_alu_out_type;
endpackage

// ==== verilog/bam_alu.sv ====
//==========================================================
// Purpose: combinational 8 bit alu and 8x8 multiplier
// Assumes: operands already selected
// Notes:   subtraction carry flags mean no borrow
`timescale 1ns/1ps
module bam_alu
#(
	parameter int W = 8
)
(
	// operands
	input  wire logic [3:0]     op,
	input  wire logic [W-1:0]   acc,
	input  wire logic [W-1:0]   fval,
	input  wire logic           cin,
	// results
	output bam_pkg::bam_alu_out_type res,
	output logic [2*W-1:0]      prod
);
	logic [W:0]   sum;
	logic [4:0]   nib;
	logic         c6;
	logic [W-1:0] mag;

	// operation select, two's complement add and subtract
	always_comb
	begin
		res = '0;
		sum = '0;
		nib = '0;
		c6 = 1'b0;
		mag = '0;
		prod = acc * fval;
		case (op)
			bam_pkg::OP_ADD:
			begin
				sum = {1'b0, fval} + {1'b0, acc};
				nib = {1'b0, fval[3:0]} + {1'b0, acc[3:0]};
				// carry into the sign bit, summed one bit wider so it is kept
				mag = {1'b0, fval[W-2:0]} + {1'b0, acc[W-2:0]};
				c6 = mag[W-1];
				res.res = sum[W-1:0];
				res.c = sum[W];
				res.dc = nib[bam_pkg::NIB_BIT];
				res.ov = c6 ^ sum[W];
				res.upd_c = 1'b1;
			end
			bam_pkg::OP_SUB:
			begin
				sum = {1'b0, fval} + {1'b0, ~acc} + 9'h001;
				nib = {1'b0, fval[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
				mag = {1'b0, fval[W-2:0]} + {1'b0, ~acc[W-2:0]} + W'(1);
				c6 = mag[W-1];
				res.res = sum[W-1:0];
				res.c = sum[W];
				res.dc = nib[bam_pkg::NIB_BIT];
				res.ov = c6 ^ sum[W];
				res.upd_c = 1'b1;
			end
			bam_pkg::OP_AND: res.res = acc & fval;
			bam_pkg::OP_OR:  res.res = acc | fval;
			bam_pkg::OP_XOR: res.res = acc ^ fval;
			bam_pkg::OP_RLC:
			begin
				res.res = {fval[W-2:0], cin};
				res.c = fval[W-1];
			end
			bam_pkg::OP_RRC:
			begin
				res.res = {cin, fval[W-1:1]};
				res.c = fval[0];
			end
			bam_pkg::OP_MOVF: res.res = fval;
			default: res.res = acc;
		endcase
		res.z = (res.res == '0);
		res.upd_z = (op <= bam_pkg::OP_XOR) || (op == bam_pkg::OP_MOVF);
		if (op == bam_pkg::OP_RLC || op == bam_pkg::OP_RRC)
			res.upd_c = 1'b1;
	end
endmodule

// ==== verilog/bam_core.sv ====
//==========================================================
// Purpose: byte alu datapath with register file and two stage pipeline
// Assumes: instructions are posted over ahb-lite, one word per instruction
// Notes:   register file also holds accumulator, status, program counter, product
//
// Behaviour
// - alu works on 8 bit operands: add, subtract, shift, logic
// - arithmetic is two's complement, no sign magnitude
// - one operand from accumulator, other from any file location
// - working accumulator is an 8 bit register
// - unsigned 8x8 multiply gives 16 bit product in one cycle
// - carry, digit carry and zero flags updated per operation
// - on subtraction carry and digit carry mean no borrow
// - overflow taken from bits six and seven only
// - file to file move bypasses the accumulator
// - each instruction is one 16 bit word taken in one cycle
// - fetch overlaps execute; branches and table moves take two cycles
// - program counter, accumulator and status are file locations
`timescale 1ns/1ps
module bam_core
#(
	parameter int W     = 8,
	parameter int DEPTH = 256
)
(
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// observed state
	output logic [W-1:0]     acc_out,
	output logic [2*W-1:0]   prod_out,
	output logic             busy
);
	typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_STALL} bam_state_type;

	logic [W-1:0]  file_mem [DEPTH];
	logic [W-1:0]  working_accumulator;
	logic [W-1:0]  status;
	logic [15:0]   program_counter;
	logic [2*W-1:0] product;
	logic [31:0]   cycles;
	logic [15:0]   fetch_reg;
	logic [15:0]   exec_reg;
	logic          exec_valid;
	logic [1:0]    stall_cnt;
	bam_state_type state;

	logic          ph_write;
	logic          ph_read;
	logic [11:0]   ph_addr;

	logic [W-1:0]  next_working_accumulator;
	logic [W-1:0]  next_status;
	logic [15:0]   next_program_counter;
	logic [2*W-1:0] next_product;
	logic [31:0]   next_cycles;
	logic [15:0]   next_fetch_reg;
	logic [15:0]   next_exec_reg;
	logic          next_exec_valid;
	logic [1:0]    next_stall_cnt;
	bam_state_type next_state;
	logic          next_ph_write;
	logic          next_ph_read;
	logic [11:0]   next_ph_addr;
	logic [31:0]   next_hrdata;
	logic          next_hreadyout;
	logic          file_we;
	logic [7:0]    file_wa;
	logic [W-1:0]  file_wd;

	logic [3:0]    ex_op;
	logic [7:0]    ex_fa;
	logic          ex_dst_file;
	logic [W-1:0]  ex_fval;
	bam_pkg::bam_alu_out_type alu_res;
	logic [2*W-1:0] alu_prod;
	logic          insn_in;
	logic          bus_file;
	logic          core_idle;

	// special locations read their live registers
	function automatic logic [W-1:0] file_read(input logic [7:0] a);
		if (a == bam_pkg::LOC_ACC)
			return working_accumulator;
		else if (a == bam_pkg::LOC_STATUS)
			return status;
		else if (a == bam_pkg::LOC_PCL)
			return program_counter[7:0];
		else if (a == bam_pkg::LOC_PCH)
			return program_counter[15:8];
		else if (a == bam_pkg::LOC_PRODL)
			return product[W-1:0];
		else if (a == bam_pkg::LOC_PRODH)
			return product[2*W-1:W];
		else
			return file_mem[a];
	endfunction

	// true when location is held outside the plain array
	function automatic logic is_special(input logic [7:0] a);
		return (a == bam_pkg::LOC_ACC) || (a == bam_pkg::LOC_STATUS) || (a == bam_pkg::LOC_PCL)
			|| (a == bam_pkg::LOC_PCH) || (a == bam_pkg::LOC_PRODL) || (a == bam_pkg::LOC_PRODH);
	endfunction

	// decode of executing word
	assign ex_op = exec_reg[15:12];
	assign ex_fa = exec_reg[7:0];
	assign ex_dst_file = exec_reg[8];
	assign ex_fval = file_read(ex_fa);

	bam_alu #(.W(W)) u_alu
	(
		.op   (ex_op),
		.acc  (working_accumulator),
		.fval (ex_fval),
		.cin  (status[bam_pkg::FLG_C]),
		.res  (alu_res),
		.prod (alu_prod)
	);

	// a whole word posted to the instruction address
	assign insn_in = ph_write && (ph_addr == bam_pkg::ADDR_INSN);
	// a write data phase aimed at the register file window
	assign bus_file = ph_write && ((ph_addr & bam_pkg::FILE_MASK) == bam_pkg::ADDR_FILE);

	// pipeline, execute and bus next values
	always_comb
	begin
		next_working_accumulator = working_accumulator;
		next_status = status;
		next_program_counter = program_counter;
		next_product = product;
		next_cycles = cycles;
		next_fetch_reg = fetch_reg;
		next_exec_reg = exec_reg;
		next_exec_valid = exec_valid;
		next_stall_cnt = stall_cnt;
		next_state = state;
		next_ph_write = 1'b0;
		next_ph_read = 1'b0;
		next_ph_addr = ph_addr;
		next_hrdata = hrdata;
		next_hreadyout = 1'b1;
		file_we = 1'b0;
		file_wa = ex_fa;
		file_wd = alu_res.res;
		// execute stage
		if (state == ST_EXEC && exec_valid)
		begin
			next_cycles = cycles + 32'h0000_0001;
			next_program_counter = program_counter + 16'h0001;
			case (ex_op)
				bam_pkg::OP_MUL: next_product = alu_prod;
				bam_pkg::OP_MOVFF:
				begin
					file_wa = exec_reg[11:4];
					file_wd = file_read({4'h0, exec_reg[3:0]});
					file_we = 1'b1;
				end
				bam_pkg::OP_MOVW:
				begin
					file_wd = working_accumulator;
					file_we = 1'b1;
				end
				bam_pkg::OP_BRA, bam_pkg::OP_TBL:
				begin
					if (ex_op == bam_pkg::OP_BRA)
						next_program_counter = {program_counter[15:8], ex_fa};
					next_stall_cnt = 2'(bam_pkg::STALL_CYCLES);
					next_state = ST_STALL;
				end
				bam_pkg::OP_NOP: ;
				default:
				begin
					if (ex_dst_file)
						file_we = 1'b1;
					else
						next_working_accumulator = alu_res.res;
					if (alu_res.upd_c)
					begin
						next_status[bam_pkg::FLG_C] = alu_res.c;
						next_status[bam_pkg::FLG_DC] = alu_res.dc;
						next_status[bam_pkg::FLG_OV] = alu_res.ov;
					end
					if (alu_res.upd_z)
						next_status[bam_pkg::FLG_Z] = alu_res.z;
				end
			endcase
			if (file_we && file_wa == bam_pkg::LOC_ACC)
				next_working_accumulator = file_wd;
			else if (file_we && file_wa == bam_pkg::LOC_STATUS)
				next_status = file_wd;
			next_exec_valid = 1'b0;
			if (next_state == ST_EXEC)
				next_state = ST_IDLE;
		end
		else if (state == ST_STALL)
		begin
			next_stall_cnt = stall_cnt - 2'h1;
			next_cycles = cycles + 32'h0000_0001;
			if (stall_cnt == 2'h1)
				next_state = ST_IDLE;
		end
		// core free once this cycle's work is done
		core_idle = (next_state == ST_IDLE);
		// fetch stage overlaps execute; a word posted while busy is taken once, when free
		if (insn_in && core_idle)
		begin
			next_fetch_reg = hwdata[bam_pkg::INSN_W-1:0];
			next_exec_reg = hwdata[bam_pkg::INSN_W-1:0];
			next_exec_valid = 1'b1;
			next_state = ST_EXEC;
		end
		// bus data phase for writes to the accumulator and status
		if (ph_write && ph_addr == bam_pkg::ADDR_ACC)
			next_working_accumulator = hwdata[W-1:0];
		else if (ph_write && ph_addr == bam_pkg::ADDR_STATUS)
			next_status = hwdata[W-1:0];
		else if (bus_file && ph_addr[9:2] == bam_pkg::LOC_ACC)
			next_working_accumulator = hwdata[W-1:0];
		else if (bus_file && ph_addr[9:2] == bam_pkg::LOC_STATUS)
			next_status = hwdata[W-1:0];
		// read data
		if (ph_read)
		begin
			if (ph_addr == bam_pkg::ADDR_INSN)
				next_hrdata = {16'h0000, fetch_reg};
			else if (ph_addr == bam_pkg::ADDR_ACC)
				next_hrdata = {24'h000000, working_accumulator};
			else if (ph_addr == bam_pkg::ADDR_STATUS)
				next_hrdata = {24'h000000, status};
			else if (ph_addr == bam_pkg::ADDR_PROD)
				next_hrdata = {16'h0000, product};
			else if (ph_addr == bam_pkg::ADDR_PC)
				next_hrdata = {16'h0000, program_counter};
			else if (ph_addr == bam_pkg::ADDR_CYCLES)
				next_hrdata = cycles;
			else if ((ph_addr & bam_pkg::FILE_MASK) == bam_pkg::ADDR_FILE)
				next_hrdata = {24'h000000, file_read(ph_addr[9:2])};
			else
				next_hrdata = 32'h0000_0000;
		end
		// address phase: taken when hready is high on a selected nonseq word transfer; the data phase stalls while the core works
		if (hsel && hready && htrans == bam_pkg::HTRANS_NONSEQ && hsize == bam_pkg::HSIZE_WORD)
		begin
			next_ph_write = hwrite;
			next_ph_read = !hwrite;
			next_ph_addr = haddr[11:0];
		end
		// reads take one wait state so the registered data stands at the ready edge
		if (next_ph_read || (next_ph_write && (next_state != ST_IDLE)))
			next_hreadyout = 1'b0;
		// hold the data phase while busy; a read also waits out an execute cycle
		if (!hreadyout && (!core_idle || (ph_read && state == ST_EXEC)))
		begin
			next_ph_write = ph_write;
			next_ph_read = ph_read;
			next_hreadyout = 1'b0;
		end
	end

	// pipeline and bus registers
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			working_accumulator <= '0;
			status <= '0;
			program_counter <= '0;
			product <= '0;
			cycles <= '0;
			fetch_reg <= '0;
			exec_reg <= '0;
			exec_valid <= 1'b0;
			stall_cnt <= '0;
			state <= ST_IDLE;
			ph_write <= 1'b0;
			ph_read <= 1'b0;
			ph_addr <= '0;
			hrdata <= '0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			acc_out <= '0;
			prod_out <= '0;
			busy <= 1'b0;
		end
		else
		begin
			working_accumulator <= next_working_accumulator;
			status <= next_status;
			program_counter <= next_program_counter;
			product <= next_product;
			cycles <= next_cycles;
			fetch_reg <= next_fetch_reg;
			exec_reg <= next_exec_reg;
			exec_valid <= next_exec_valid;
			stall_cnt <= next_stall_cnt;
			state <= next_state;
			ph_write <= next_ph_write;
			ph_read <= next_ph_read;
			ph_addr <= next_ph_addr;
			hrdata <= next_hrdata;
			hreadyout <= next_hreadyout;
			hresp <= 1'b0;
			acc_out <= next_working_accumulator;
			prod_out <= next_product;
			busy <= (next_state != ST_IDLE);
		end
	end

	// plain file array, written by execute or by the bus
	always_ff @(posedge sys_clk)
	begin
		if (file_we && !is_special(file_wa))
			file_mem[file_wa] <= file_wd;
		else if (bus_file && !is_special(ph_addr[9:2]))
			file_mem[ph_addr[9:2]] <= hwdata[W-1:0];
	end

	// product follows the multiply in the very next cycle
	property p_mul_one_cycle;
		@(posedge sys_clk) disable iff (rst)
		(state == ST_EXEC && exec_valid && ex_op == bam_pkg::OP_MUL) |=> (product == $past(alu_prod));
	endproperty
	a_mul_one_cycle: assert property (p_mul_one_cycle) else $error("product not loaded");

	property p_zero_flag;
		@(posedge sys_clk) disable iff (rst)
		(state == ST_EXEC && exec_valid && ex_op == bam_pkg::OP_ADD && !ex_dst_file)
		|=> (status[bam_pkg::FLG_Z] == (working_accumulator == '0));
	endproperty
	a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong");

	property p_sub_borrow;
		@(posedge sys_clk) disable iff (rst)
		(state == ST_EXEC && exec_valid && ex_op == bam_pkg::OP_SUB)
		|=> (status[bam_pkg::FLG_C] == ($past(ex_fval) >= $past(working_accumulator)));
	endproperty
	a_sub_borrow: assert property (p_sub_borrow) else $error("borrow flag wrong");

	property p_add_carry;
		@(posedge sys_clk) disable iff (rst)
		(state == ST_EXEC && exec_valid && ex_op == bam_pkg::OP_ADD)
		|=> (status[bam_pkg::FLG_C] == (({1'b0, $past(ex_fval)} + {1'b0, $past(working_accumulator)}) > 9'h0FF));
	endproperty
	a_add_carry: assert property (p_add_carry) else $error("carry flag wrong");

	property p_ov_add;
		@(posedge sys_clk) disable iff (rst)
		(state == ST_EXEC && exec_valid && ex_op == bam_pkg::OP_ADD)
		|=> (status[bam_pkg::FLG_OV] == (($past(ex_fval[7]) == $past(working_accumulator[7]))
			&& ($past(alu_res.res[7]) != $past(ex_fval[7]))));
	endproperty
	a_ov_add: assert property (p_ov_add) else $error("overflow flag wrong");

	property p_branch_stall;
		@(posedge sys_clk) disable iff (rst)
		(state == ST_EXEC && exec_valid && ex_op == bam_pkg::OP_BRA && !insn_in) |=> (state == ST_STALL) ##1 (state != ST_STALL);
	endproperty
	a_branch_stall: assert property (p_branch_stall) else $error("branch not two cycles");

	property p_single_cycle;
		@(posedge sys_clk) disable iff (rst)
		(state == ST_EXEC && exec_valid && ex_op == bam_pkg::OP_ADD && !insn_in) |=> (state == ST_IDLE);
	endproperty
	a_single_cycle: assert property (p_single_cycle) else $error("alu op not single cycle");

	property p_move_keeps_acc;
		@(posedge sys_clk) disable iff (rst)
		(state == ST_EXEC && exec_valid && ex_op == bam_pkg::OP_MOVFF && exec_reg[11:4] != bam_pkg::LOC_ACC && !ph_write)
		|=> $stable(working_accumulator);
	endproperty
	a_move_keeps_acc: assert property (p_move_keeps_acc) else $error("move touched accumulator");

	property p_pc_count;
		@(posedge sys_clk) disable iff (rst)
		(state == ST_EXEC && exec_valid && ex_op == bam_pkg::OP_NOP) |=> (program_counter == $past(program_counter) + 16'h0001);
	endproperty
	a_pc_count: assert property (p_pc_count) else $error("program counter not advanced");
endmodule

// ==== verif/bam_core_tb.sv ====
//==========================================================
// Purpose: self-checking bench of the byte alu datapath
// Assumes: one ahb-lite master, hready looped from hreadyout
// Notes:   reads queue their expected word, a monitor compares
`timescale 1ns/1ps
module byte_alu_multiplier_datapath_tb;
	// clock, reset and bus master signals
	logic        sys_clk  = 1'b0;
	logic        rst      = 1'b1;
	logic        hsel     = 1'b0;
	logic [31:0] haddr    = 32'h0;
	logic [1:0]  htrans   = 2'h0;
	logic        hwrite   = 1'b0;
	logic [2:0]  hsize    = 3'h0;
	logic [31:0] hwdata   = 32'h0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic [7:0]  acc_out;
	logic [15:0] prod_out;
	logic        busy;
	// bench state
	logic        rd_phase = 1'b0;
	logic [31:0] exp_q[$];
	logic [31:0] seed     = 32'h6;
	int          failures = 0;
	int          checked  = 0;

	//==========================================================
	// clock and design
	always #4 sys_clk = ~sys_clk;

	bam_core #(.W(8), .DEPTH(256)) i_dut (
		.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.acc_out(acc_out), .prod_out(prod_out), .busy(busy));

	//==========================================================
	// helpers
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			failures++;
			$display("[ERR] %0t got %08h expected %08h", $time, got, exp);
		end
	endtask

	task automatic finish_test();
		if (failures == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// byte address of a register file location
	function automatic logic [11:0] fa(input logic [7:0] loc);
		return bam_pkg::ADDR_FILE | {2'h0, loc, 2'h0};
	endfunction

	// expected {status, result} of one operation
	function automatic logic [11:0] model(input logic [3:0] op, input logic [7:0] a,
		input logic [7:0] f, input logic ci);
		logic [7:0] b;
		logic       sb;
		logic [8:0] s;
		logic [4:0] n;
		logic [7:0] m;
		logic [7:0] r;
		logic [3:0] st;
		sb = (op == bam_pkg::OP_SUB);
		b  = sb ? ~a : a;
		s  = {1'b0, f} + {1'b0, b} + {8'h0, sb};
		n  = {1'b0, f[3:0]} + {1'b0, b[3:0]} + {4'h0, sb};
		m  = {1'b0, f[6:0]} + {1'b0, b[6:0]} + {7'h0, sb};
		r  = a;
		st = 4'h0;
		case (op)
			bam_pkg::OP_ADD, bam_pkg::OP_SUB: r = s[7:0];
			bam_pkg::OP_AND: r = a & f;
			bam_pkg::OP_OR: r = a | f;
			bam_pkg::OP_XOR: r = a ^ f;
			bam_pkg::OP_MOVF: r = f;
			bam_pkg::OP_RLC: r = {f[6:0], ci};
			bam_pkg::OP_RRC: r = {ci, f[7:1]};
			default: r = a;
		endcase
		if (op == bam_pkg::OP_ADD || sb)
			st = {m[7] ^ s[8], r == 8'h0, n[4], s[8]};
		else if (op == bam_pkg::OP_RLC || op == bam_pkg::OP_RRC)
			st = {3'h0, (op == bam_pkg::OP_RLC) ? f[7] : f[0]};
		else if (op != bam_pkg::OP_MUL)
			st = {1'b0, r == 8'h0, 2'h0};
		return {st, r};
	endfunction

	// one single word transfer, waits on hready in both phases
	task automatic ahb(input logic [11:0] a, input logic wr, input logic [31:0] d, input logic [31:0] e);
		hsel   <= 1'b1;
		haddr  <= {20'h0, a};
		htrans <= bam_pkg::HTRANS_NONSEQ;
		hwrite <= wr;
		hsize  <= bam_pkg::HSIZE_WORD;
		@(posedge sys_clk);
		while (hreadyout !== 1'b1)
			@(posedge sys_clk);
		hsel     <= 1'b0;
		htrans   <= 2'h0;
		hwdata   <= d;
		rd_phase <= ~wr;
		if (!wr)
			exp_q.push_back(e);
		@(posedge sys_clk);
		while (hreadyout !== 1'b1)
			@(posedge sys_clk);
		rd_phase <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		ahb(a, 1'b1, d, 32'h0);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		ahb(a, 1'b0, 32'h0, e);
	endtask

	// post an instruction and count the cycles spent busy
	task automatic exec(input logic [15:0] insn, input int nb);
		int n;
		n = 0;
		wr(bam_pkg::ADDR_INSN, {16'h0, insn});
		repeat (5)
		begin
			@(posedge sys_clk);
			if (busy === 1'b1)
				n++;
		end
		check(32'(n), 32'(nb));
	endtask

	//==========================================================
	// monitor: compares read data at the closing data phase edge
	always @(posedge sys_clk)
	begin
		if (rd_phase && hreadyout === 1'b1 && exp_q.size() > 0)
		begin
			check(hrdata, exp_q.pop_front());
			check({31'h0, hresp}, 32'h0);
		end
	end

	// watchdog
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		failures++;
		finish_test();
	end

	//==========================================================
	// main sequence
	initial
	begin
		logic [3:0]  tbl [9];
		logic [3:0]  op;
		logic [31:0] r;
		logic [7:0]  a;
		logic [7:0]  f;
		logic [7:0]  loc;
		logic        ci;
		logic        dst;
		logic [11:0] e;
		tbl = '{bam_pkg::OP_ADD, bam_pkg::OP_SUB, bam_pkg::OP_AND, bam_pkg::OP_OR, bam_pkg::OP_XOR,
			bam_pkg::OP_RLC, bam_pkg::OP_RRC, bam_pkg::OP_MOVF, bam_pkg::OP_MUL};
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		// reset values and an unmapped place
		rd(bam_pkg::ADDR_ACC, 32'h0);
		rd(bam_pkg::ADDR_STATUS, 32'h0);
		rd(bam_pkg::ADDR_PROD, 32'h0);
		rd(12'h020, 32'h0);
		// each of the nine operations in tbl: two boundary rounds, then random
		for (int i = 0; i < 36; i++)
		begin
			op  = tbl[i % 9];
			r   = rnd();
			a   = r[7:0];
			f   = r[15:8];
			loc = {2'h1, r[21:16]};
			ci  = r[22] && (op == bam_pkg::OP_RLC || op == bam_pkg::OP_RRC);
			dst = r[23] && op != bam_pkg::OP_MUL;
			if (i < 9)
				{a, f} = 16'hFF01;
			else if (i < 18)
				{a, f} = 16'h4040;
			wr(fa(loc), {24'h0, f});
			wr(bam_pkg::ADDR_ACC, {24'h0, a});
			wr(bam_pkg::ADDR_STATUS, {31'h0, ci});
			exec({op, 3'h0, dst, loc}, 1);
			e = model(op, a, f, ci);
			rd(bam_pkg::ADDR_ACC, {24'h0, dst ? a : e[7:0]});
			rd(fa(loc), {24'h0, dst ? e[7:0] : f});
			rd(bam_pkg::ADDR_STATUS, {28'h0, e[11:8]});
			check({24'h0, acc_out}, {24'h0, dst ? a : e[7:0]});
			if (op == bam_pkg::OP_MUL)
			begin
				rd(bam_pkg::ADDR_PROD, {16'h0, 16'(a) * 16'(f)});
				check({16'h0, prod_out}, {16'h0, 16'(a) * 16'(f)});
			end
		end
		// special registers seen as file locations
		wr(fa(bam_pkg::LOC_ACC), 32'h5A);
		rd(bam_pkg::ADDR_ACC, 32'h5A);
		wr(bam_pkg::ADDR_STATUS, 32'h5);
		rd(fa(bam_pkg::LOC_STATUS), 32'h5);
		// product is read only and mirrored in the file
		wr(fa(8'h0E), 32'h11);
		wr(bam_pkg::ADDR_ACC, 32'h0F);
		exec({bam_pkg::OP_MUL, 4'h0, 8'h0E}, 1);
		wr(bam_pkg::ADDR_PROD, rnd());
		rd(bam_pkg::ADDR_PROD, 32'hFF);
		rd(fa(bam_pkg::LOC_PRODL), 32'hFF);
		rd(fa(bam_pkg::LOC_PRODH), 32'h0);
		// file to file move leaves the accumulator alone
		exec({bam_pkg::OP_MOVFF, 8'h50, 4'hE}, 1);
		rd(fa(8'h50), 32'h11);
		rd(bam_pkg::ADDR_ACC, 32'h0F);
		// branch and table move take a second cycle
		exec({bam_pkg::OP_BRA, 4'h0, 8'h33}, 2);
		exec({bam_pkg::OP_TBL, 12'h0}, 2);
		exec({bam_pkg::OP_NOP, 12'h0}, 1);
		// read right behind an instruction waits for its result
		wr(bam_pkg::ADDR_INSN, {16'h0, bam_pkg::OP_ADD, 4'h0, 8'h0E});
		rd(bam_pkg::ADDR_ACC, 32'h20);
		finish_test();
	end
endmodule
